// ### rtl/pfc_map.svh
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH
// Feature control bit positions
`define PFC_BIT_IOBP 3
`define PFC_BIT_LPE 4
`define PFC_BIT_WAE 5
`define PFC_BIT_MCE 6
`define PFC_BIT_GPE 7
`define PFC_BIT_CRO 8
`define PFC_BIT_LSE 9
`define PFC_BIT_SFS 10
`define PFC_BIT_SBE 16
`define PFC_BIT_ESM 18
// Writable bits: 0..10, 16, 18; everything else reads zero
`define PFC_WR_MASK 64'h0000_0000_0005_07FF
`define PFC_RESET 64'h0000_0000_0000_0000
`define PFC_LOW_MASK 64'h0000_0000_FFFF_FFFF
// Control register numbers
`define PFC_CR_PGBASE 4'h3
`define PFC_CR_FEAT 4'h4
`define PFC_CR_TPC 4'h8
// Debug register numbers
`define PFC_DR_ALO 3'h4
`define PFC_DR_AHI 3'h5
`define PFC_DR_STAT 3'h6
`define PFC_DR_CTRL 3'h7
// Task priority width and reset
`define PFC_TPC_W 4
`define PFC_TPC_RESET 4'h0
`endif

// ### rtl/pfc_pkg.sv
package pfc_pkg;
  // Page size chosen by translation
  typedef enum logic [1:0] {
    PFC_PG_4K,
    PFC_PG_2M,
    PFC_PG_4M
  } pfc_page_t;
  // Activity state of the register port, busy after any move
  typedef enum logic [0:0] {
    PFC_IDLE,
    PFC_BUSY
  } pfc_state_t;
endpackage : pfc_pkg

// ### rtl/pfc_cr_decode.sv
`timescale 1ns/1ps
`include "pfc_map.svh"
// Control register number legality check
module pfc_cr_decode (
  input wire logic [2:0] reg_field_in,
  input wire logic reg_extend_in,
  input wire logic long64_in,
  input wire logic [7:0] impl_hi_in,
  output logic [3:0] cr_num_out,
  output logic illegal_out
);
  logic [3:0] num;
  logic hi_impl;
  // Extension bit only counts in 64-bit mode
  assign num = {reg_extend_in & long64_in, reg_field_in};
  assign cr_num_out = num;
  assign hi_impl = impl_hi_in[num[2:0]];
  assign illegal_out = (num == 4'h1) || (num == 4'h5) || (num == 4'h6) ||
    (num == 4'h7) || (num[3] && !hi_impl);
endmodule : pfc_cr_decode

// ### rtl/pfc_feature_ctl.sv
`timescale 1ns/1ps
`include "pfc_map.svh"
// Behaviour
// - io_breakpoint_enable set: breakpoints on, alias debug registers fault invalid opcode.
// - io_breakpoint_enable clear: breakpoints off, aliases map to status and control.
// - large_page_enable picks 4K or 4M by large_page_select; clear means 4K.
// - large_page_enable is ignored while wide_address_enable is set.
// - wide_address_enable gives 64-bit entries, 52-bit addresses, 4K or 2M pages.
// - Long mode needs wide_address_enable set for 64-bit table format.
// - machine_check_enable set raises machine_check_fault on uncorrectable errors only.
// - Enabled errors are logged regardless; correctable ones never fault.
// - global_page_enable keeps global translations across page table base writes.
// - counter_read_open allows counter reads at any privilege, else level 0.
// - legacy_simd_enable clear faults legacy SIMD, keeps legacy save and restore.
// - simd_fp_fault_support clear turns unmasked SIMD FP faults into invalid opcode.
// - segbase_instr_enable allows segment-base instructions in 64-bit mode, any privilege.
// - ext_state_mgmt_enable allows mask read/write and extended save of enabled states.
// - Control registers 1, 5-7 and unimplemented 8-15 fault invalid opcode.
// - In 64-bit mode the extend bit selects control registers 8 to 15.
// - Task priority control is register 8, reachable only in 64-bit mode.
// - Outside 64-bit mode only low 32 bits show; reserved bits read zero.
module pfc_feature_ctl
  import pfc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Mode and privilege
  input wire logic long64_in,
  input wire logic [1:0] cpl_in,
  input wire logic [7:0] impl_hi_in,
  input wire logic segbase_supported_in,
  input wire logic ext_state_supported_in,
  // Control register move
  input wire logic cr_valid_in,
  input wire logic cr_write_in,
  input wire logic [2:0] cr_field_in,
  input wire logic prefix_reg_extend_bit_in,
  input wire logic [63:0] cr_wdata_in,
  output logic [63:0] cr_rdata_out,
  output logic cr_done_out,
  output logic [3:0] task_priority_ctl_out,
  output logic tlb_flush_nonglobal_out,
  output logic tlb_flush_all_out,
  // Debug register access
  input wire logic dr_valid_in,
  input wire logic [2:0] dr_num_in,
  output logic [2:0] dr_target_out,
  output logic dr_target_valid_out,
  // Instruction checks
  input wire logic perf_counter_read_instr_in,
  input wire logic legacy_simd_instr_in,
  input wire logic legacy_save_instr_in,
  input wire logic segbase_instr_in,
  input wire logic ext_mask_instr_in,
  input wire logic ext_save_instr_in,
  input wire logic simd_fp_unmasked_in,
  output logic invalid_opcode_fault_out,
  output logic general_protect_fault_out,
  output logic simd_fp_fault_out,
  // Machine check
  input wire logic mc_error_in,
  input wire logic mc_uncorrectable_in,
  input wire logic mc_bank_enabled_in,
  output logic machine_check_fault_out,
  output logic mc_log_out,
  // Translation decode
  input wire logic large_page_select_in,
  output pfc_page_t page_size_out,
  output logic wide_entries_out,
  output logic global_keep_out,
  output logic io_breakpoint_on_out,
  output logic [63:0] feature_control_reg_out
);
  logic [63:0] feat_q, feat_d;
  logic [3:0] tpc_q, tpc_d;
  logic [63:0] rdata_q, rdata_d;
  logic done_q, fault_q, gp_q, xf_q, mcf_q, mclog_q;
  logic flush_ng_q, flush_all_q;
  logic [2:0] drt_q;
  logic drv_q;
  pfc_page_t page_q;
  pfc_state_t state_q;
  logic [3:0] cr_num;
  logic cr_illegal;
  // Decoded feature bits
  wire iobp = feat_q[`PFC_BIT_IOBP];
  wire lpe = feat_q[`PFC_BIT_LPE];
  wire wae = feat_q[`PFC_BIT_WAE];
  wire machine_check_enable = feat_q[`PFC_BIT_MCE];
  wire gpe = feat_q[`PFC_BIT_GPE];
  wire cro = feat_q[`PFC_BIT_CRO];
  wire lse = feat_q[`PFC_BIT_LSE];
  wire sfs = feat_q[`PFC_BIT_SFS];
  wire sbe = feat_q[`PFC_BIT_SBE];
  wire esm = feat_q[`PFC_BIT_ESM];

  pfc_cr_decode u_dec (
    .reg_field_in(cr_field_in),
    .reg_extend_in(prefix_reg_extend_bit_in),
    .long64_in(long64_in),
    .impl_hi_in(impl_hi_in),
    .cr_num_out(cr_num),
    .illegal_out(cr_illegal)
  );

  // Register moves
  wire cr_ok = cr_valid_in && !cr_illegal;
  wire wr_feat = cr_ok && cr_write_in && (cr_num == `PFC_CR_FEAT);
  wire wr_pgbase = cr_ok && cr_write_in && (cr_num == `PFC_CR_PGBASE);
  wire wr_tpc = cr_ok && cr_write_in && (cr_num == `PFC_CR_TPC);
  wire [63:0] feat_view = long64_in ? feat_q : (feat_q & `PFC_LOW_MASK);
  // Reserved bits are dropped on write so they always read zero
  assign feat_d = wr_feat ? (cr_wdata_in & `PFC_WR_MASK) : feat_q;
  assign tpc_d = wr_tpc ? cr_wdata_in[`PFC_TPC_W-1:0] : tpc_q;
  assign rdata_d = !cr_ok ? 64'h0 :
    (cr_num == `PFC_CR_FEAT) ? feat_view :
    (cr_num == `PFC_CR_TPC) ? {60'h0, tpc_q} : 64'h0;

  // Debug alias handling
  wire dr_alias = (dr_num_in == `PFC_DR_ALO) || (dr_num_in == `PFC_DR_AHI);
  wire dr_fault = dr_valid_in && dr_alias && iobp;
  wire [2:0] dr_map = (!iobp && dr_num_in == `PFC_DR_ALO) ? `PFC_DR_STAT :
    (!iobp && dr_num_in == `PFC_DR_AHI) ? `PFC_DR_CTRL : dr_num_in;

  // Instruction permission checks
  wire pmc_gp = perf_counter_read_instr_in && !cro && (cpl_in != 2'h0);
  wire simd_ud = legacy_simd_instr_in && !legacy_save_instr_in && !lse;
  wire sb_ud = segbase_instr_in && !(sbe && segbase_supported_in && long64_in);
  // Extended save only meaningful when legacy SIMD is also on, as software is expected to ensure
  wire xs_ud = (ext_mask_instr_in || ext_save_instr_in) &&
    !(esm && ext_state_supported_in);
  wire xf_ud = simd_fp_unmasked_in && !sfs;
  wire xf_go = simd_fp_unmasked_in && sfs;
  // Every refusal except the counter read one folds into the one invalid opcode pulse
  wire cr_ud = cr_valid_in && cr_illegal;
  wire ud = dr_fault || cr_ud || simd_ud || sb_ud || xs_ud || xf_ud;

  // Machine check
  wire mc_go = mc_error_in && mc_uncorrectable_in && machine_check_enable;
  wire mc_lg = mc_error_in && mc_bank_enabled_in;

  // Page size: wide addressing overrides large page enable
  pfc_page_t page_d;
  assign page_d = wae ? (large_page_select_in ? PFC_PG_2M : PFC_PG_4K) :
    ((lpe && large_page_select_in) ? PFC_PG_4M : PFC_PG_4K);

  // Feature register, all extensions off after reset
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      feat_q <= `PFC_RESET;
    end else begin
      feat_q <= feat_d;
    end
  end

  // Task priority control, written only through register 8
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tpc_q <= `PFC_TPC_RESET;
    end else begin
      tpc_q <= tpc_d;
    end
  end

  // Read data; a read beside a write still returns the old value
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rdata_q <= 64'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Move done, one pulse per request
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      done_q <= 1'b0;
    end else begin
      done_q <= cr_valid_in;
    end
  end

  // Port activity tracker, back to back moves keep it busy
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q <= PFC_IDLE;
    end else begin
      case (state_q)
        PFC_IDLE: state_q <= cr_valid_in ? PFC_BUSY : PFC_IDLE;
        PFC_BUSY: state_q <= cr_valid_in ? PFC_BUSY : PFC_IDLE;
        default: state_q <= PFC_IDLE;
      endcase
    end
  end

  // Invalid opcode pulse, one cycle after the request
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= ud;
    end
  end

  // Counter read privilege refusal
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      gp_q <= 1'b0;
    end else begin
      gp_q <= pmc_gp;
    end
  end

  // SIMD floating-point fault, only when its handler is declared
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      xf_q <= 1'b0;
    end else begin
      xf_q <= xf_go;
    end
  end

  // Machine check fault
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mcf_q <= 1'b0;
    end else begin
      mcf_q <= mc_go;
    end
  end

  // Error logging ignores the fault enable on purpose
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mclog_q <= 1'b0;
    end else begin
      mclog_q <= mc_lg;
    end
  end

  // Non-global flush, global entries survive a base write
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      flush_ng_q <= 1'b0;
    end else begin
      flush_ng_q <= wr_pgbase && gpe;
    end
  end

  // Full flush when global pages are off
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      flush_all_q <= 1'b0;
    end else begin
      flush_all_q <= wr_pgbase && !gpe;
    end
  end

  // Mapped debug register number
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      drt_q <= 3'h0;
    end else begin
      drt_q <= dr_map;
    end
  end

  // Debug access goes ahead unless refused
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      drv_q <= 1'b0;
    end else begin
      drv_q <= dr_valid_in && !dr_fault;
    end
  end

  // Page size follows the feature bits of the previous cycle
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      page_q <= PFC_PG_4K;
    end else begin
      page_q <= page_d;
    end
  end

  // Outputs straight from the flops
  assign cr_rdata_out = rdata_q;
  assign cr_done_out = done_q;
  assign task_priority_ctl_out = tpc_q;
  assign tlb_flush_nonglobal_out = flush_ng_q;
  assign tlb_flush_all_out = flush_all_q;
  assign dr_target_out = drt_q;
  assign dr_target_valid_out = drv_q;
  assign invalid_opcode_fault_out = fault_q;
  assign general_protect_fault_out = gp_q;
  assign simd_fp_fault_out = xf_q;
  assign machine_check_fault_out = mcf_q;
  assign mc_log_out = mclog_q;
  assign page_size_out = page_q;
  assign wide_entries_out = feat_q[`PFC_BIT_WAE];
  assign global_keep_out = feat_q[`PFC_BIT_GPE];
  assign io_breakpoint_on_out = feat_q[`PFC_BIT_IOBP];
  assign feature_control_reg_out = feat_q;
endmodule : pfc_feature_ctl

// ### test/pfc_feature_ctl_asserts.sv
`timescale 1ns/1ps
// Port-level timing checks, one cycle from request to answer, plus a same-cycle reserved-bit check
module pfc_feature_ctl_asserts
  import pfc_pkg::*;
(
  input wire logic core_clk_in, reset_in, long64_in, prefix_reg_extend_bit_in,
  input wire logic cr_valid_in, dr_valid_in, mc_error_in, mc_uncorrectable_in,
  input wire logic mc_bank_enabled_in, perf_counter_read_instr_in, simd_fp_unmasked_in,
  input wire logic large_page_select_in, dr_target_valid_out, invalid_opcode_fault_out,
  input wire logic simd_fp_fault_out, general_protect_fault_out, machine_check_fault_out,
  input wire logic mc_log_out,
  input wire logic [1:0] cpl_in,
  input wire logic [2:0] cr_field_in, dr_num_in, dr_target_out,
  input wire pfc_page_t page_size_out,
  input wire logic [63:0] feature_control_reg_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // Short alias of the register image
  wire logic [63:0] fcr = feature_control_reg_out;

  AST_DR_FAULT: assert property (dr_valid_in && fcr[3] && dr_num_in[2:1] == 2'h2 |=>
    invalid_opcode_fault_out && !dr_target_valid_out) else $error("alias not refused");
  AST_DR_ALIAS: assert property (dr_valid_in && !fcr[3] && dr_num_in[2:1] == 2'h2 |=>
    dr_target_valid_out && dr_target_out == {2'h3, $past(dr_num_in[0])})
    else $error("alias not redirected");
  AST_WIDE_PAGE: assert property (fcr[5] && $stable(fcr) |->
    page_size_out == ($past(large_page_select_in) ? PFC_PG_2M : PFC_PG_4K))
    else $error("wide page size wrong");
  AST_MC_FAULT: assert property (mc_error_in && mc_uncorrectable_in |=>
    machine_check_fault_out == $past(fcr[6])) else $error("machine check fault wrong");
  AST_MC_LOG: assert property (mc_error_in && mc_bank_enabled_in |=> mc_log_out)
    else $error("error not logged");
  AST_CTR_PRIV: assert property (perf_counter_read_instr_in && cpl_in != 2'h0 |=>
    general_protect_fault_out == !$past(fcr[8])) else $error("counter read privilege wrong");
  AST_XF_ROUTE: assert property (simd_fp_unmasked_in && !fcr[10] |=>
    invalid_opcode_fault_out && !simd_fp_fault_out) else $error("fp fault not rerouted");
  AST_CR_RESV: assert property (cr_valid_in && !(long64_in && prefix_reg_extend_bit_in) &&
    (cr_field_in == 3'h1 || cr_field_in > 3'h4) |=> invalid_opcode_fault_out)
    else $error("reserved control register accepted");
  AST_MBZ: assert property ((fcr & ~64'h0000_0000_0005_07FF) == 64'h0)
    else $error("reserved bit set");
endmodule : pfc_feature_ctl_asserts

bind pfc_feature_ctl pfc_feature_ctl_asserts pfc_feature_ctl_asserts_inst (.*);

// ### test/tb.sv
`timescale 1ns/1ps
`include "pfc_map.svh"
module tb;
  import pfc_pkg::*;
  logic core_clk_in = 0, reset_in = 1, long64_in = 0, cr_valid_in = 0, cr_write_in = 0;
  logic prefix_reg_extend_bit_in = 0, perf_counter_read_instr_in, legacy_simd_instr_in;
  logic legacy_save_instr_in, segbase_instr_in, ext_mask_instr_in, ext_save_instr_in;
  logic simd_fp_unmasked_in, mc_error_in, mc_uncorrectable_in, mc_bank_enabled_in;
  logic large_page_select_in, segbase_supported_in, ext_state_supported_in, dr_valid_in;
  logic cr_done_out, tlb_flush_nonglobal_out, tlb_flush_all_out, dr_target_valid_out;
  logic invalid_opcode_fault_out, general_protect_fault_out, simd_fp_fault_out, mc_log_out;
  logic machine_check_fault_out, wide_entries_out, global_keep_out, io_breakpoint_on_out;
  logic [1:0] cpl_in;
  logic [2:0] cr_field_in = 0, dr_num_in, dr_target_out;
  logic [3:0] task_priority_ctl_out;
  logic [7:0] impl_hi_in = 8'h01;
  logic [63:0] cr_wdata_in = 0, cr_rdata_out, feature_control_reg_out, d;
  pfc_page_t page_size_out;
  int errors = 0, compares = 0, cyc = 0;

  pfc_feature_ctl pfc_feature_ctl_inst (.*);

  // Free-running core clock
  initial forever #20 core_clk_in = ~core_clk_in;

  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // Hang guard, far above the roughly 540 cycles needed
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end

  // Extended numbers go by the implemented mask, else only 0 and 2 to 4
  function automatic logic legal(logic [2:0] f, logic ext, logic [7:0] hi);
    return ext ? hi[f] : f != 3'h1 && f < 3'h5;
  endfunction : legal

  task automatic stim(logic en);
    {perf_counter_read_instr_in, legacy_simd_instr_in, legacy_save_instr_in, segbase_instr_in,
      ext_mask_instr_in, ext_save_instr_in, simd_fp_unmasked_in, mc_error_in,
      mc_uncorrectable_in, mc_bank_enabled_in, large_page_select_in, cpl_in,
      segbase_supported_in, ext_state_supported_in, dr_valid_in, dr_num_in} = en ? $urandom : 0;
  endtask : stim

  // Expected answers to one cycle of instruction traffic, from the feature bits
  task automatic ins_chk;
    logic [63:0] f;
    logic al;
    f = feature_control_reg_out;
    al = dr_num_in[2:1] == 2'h2;
    chk(invalid_opcode_fault_out, dr_valid_in && al && f[3] ||
      legacy_simd_instr_in && !legacy_save_instr_in && !f[9] ||
      segbase_instr_in && !(f[16] && segbase_supported_in && long64_in) ||
      (ext_mask_instr_in || ext_save_instr_in) && !(f[18] && ext_state_supported_in) ||
      simd_fp_unmasked_in && !f[10]);
    chk(general_protect_fault_out, perf_counter_read_instr_in && !f[8] && cpl_in != 2'h0);
    chk(simd_fp_fault_out, simd_fp_unmasked_in && f[10]);
    chk(machine_check_fault_out, mc_error_in && mc_uncorrectable_in && f[6]);
    chk(mc_log_out, mc_error_in && mc_bank_enabled_in);
    chk(dr_target_valid_out, dr_valid_in && !(al && f[3]));
    chk(dr_target_out, al && !f[3] ? {2'h3, dr_num_in[0]} : dr_num_in);
    chk(page_size_out, f[5] ? (large_page_select_in ? PFC_PG_2M : PFC_PG_4K) :
      (f[4] && large_page_select_in ? PFC_PG_4M : PFC_PG_4K));
    chk({wide_entries_out, global_keep_out, io_breakpoint_on_out}, {f[5], f[7], f[3]});
  endtask : ins_chk

  // One control register move, held for exactly one sampling edge
  task automatic op(logic w, logic [2:0] f, logic x, logic l, logic [63:0] v);
    logic [63:0] old;
    logic [3:0] tp;
    logic ok, f4, f3, t8;
    @(posedge core_clk_in);
    #1;
    old = feature_control_reg_out;
    tp = task_priority_ctl_out;
    ok = legal(f, x && l, impl_hi_in);
    f4 = f == 3'h4 && !(x && l);
    f3 = f == 3'h3 && !(x && l);
    t8 = f == 3'h0 && x && l;
    {cr_valid_in, cr_write_in, cr_field_in, prefix_reg_extend_bit_in, long64_in} = {1'b1, w, f, x, l};
    cr_wdata_in = v;
    @(posedge core_clk_in);
    #1;
    cr_valid_in = 0;
    chk(cr_done_out, 1);
    chk(invalid_opcode_fault_out, !ok);
    chk(feature_control_reg_out, w && f4 ? v & `PFC_WR_MASK : old);
    chk(task_priority_ctl_out, w && t8 ? v[3:0] : tp);
    chk({tlb_flush_nonglobal_out, tlb_flush_all_out}, w && f3 ? {old[7], !old[7]} : 2'h0);
    if (!w) chk(cr_rdata_out, f4 ? (l ? old : old & `PFC_LOW_MASK) : t8 ? tp : 0);
  endtask : op

  initial begin
    void'($urandom(32'hC9475AC5));
    stim(0);
    repeat (20) @(posedge core_clk_in);
    #1 reset_in = 0;
    chk(feature_control_reg_out, 0);
    // Corners: all ones, readback in both modes, a refused number, a register 8 write
    op(1, 3'h4, 0, 0, '1);
    op(0, 3'h4, 0, 0, 0);
    op(0, 3'h4, 0, 1, 0);
    op(1, 3'h1, 1, 0, '1);
    op(1, 3'h0, 1, 1, 64'hA);
    repeat (60) begin
      impl_hi_in = $urandom | 1;
      op($urandom, $urandom, $urandom, $urandom, {$urandom, $urandom});
    end
    // Random feature settings with random instruction traffic
    repeat (30) begin
      d = {$urandom, $urandom};
      d[18] = d[18] & d[9];
      op(1, 3'h4, $urandom, $urandom, d);
      for (int k = 0; k < 11; k++) begin
        @(posedge core_clk_in);
        #1;
        ins_chk();
        stim(k < 10);
      end
    end
    wrap_up();
  end
endmodule : tb
